/* File: hdl/tpb_timer.v */
// 8-bit down timer with prescaler, pwm and buzzer on a shared pin, avalon-mm slave
// Contract
// [RULE_01] count read returns live down-counter value
// [RULE_02] count write loads reload and counter together
// [RULE_03] counter counts only while run enable set
// [RULE_04] continuous, reload select zero: wrap to FF
// [RULE_05] continuous, reload select one: reload held value
// [RULE_06] one-shot counts down once, stops at underflow
// [RULE_07] polarity bit one makes pwm active low
// [RULE_08] pwm enable puts pwm on pin two
// [RULE_09] pwm inactive until count equals duty
// [RULE_10] reload sets frame, duty register sets duty
// [RULE_11] prescaler rate code divides by 2^(code+1)
// [RULE_12] prescaler bit zero inserts, one bypasses
// [RULE_13] software changes rate only while prescaler bypassed
// [RULE_14] edge select one falling, zero rising
// [RULE_15] clock source one external pin, zero instruction
// [RULE_16] prescaler value register reads counter, resets FF
// [RULE_17] buzzer codes 0-7 divide prescaler output
// [RULE_18] buzzer codes 8-15 route timer bits 0-7
// [RULE_19] buzzer enable bit turns buzzer on
// [RULE_20] duty register is write-only, reads zero
// [RULE_21] underflow sets sticky flag until software clears
// [RULE_22] pwm wins over buzzer on shared pin
`timescale 1ns/100ps
`include "tpb_regs.vh"

module tpb_timer #(
  parameter CNT_W = 8
) (
  input  wire        i_core_clk,
  input  wire        i_rst_n,
  // avalon-mm slave, word addressed
  input  wire [2:0]  i_avs_address,
  input  wire        i_avs_read,
  input  wire        i_avs_write,
  input  wire [31:0] i_avs_writedata,
  input  wire [3:0]  i_avs_byteenable,
  output wire [31:0] o_avs_readdata,
  output wire        o_avs_waitrequest,
  // pins
  input  wire        i_external_clock_pin,
  input  wire        i_gpio_out,
  input  wire        i_gpio_oe,
  output wire        o_port_pin_two,
  output wire        o_port_pin_two_oe,
  output wire        o_underflow_flag
);

  // --------------------------------------------------------------------------
  // bus handshake: one wait state, access lands on the second cycle
  // --------------------------------------------------------------------------
  reg         ack_r;
  reg  [31:0] rdata_r;
  wire        req      = i_avs_read | i_avs_write;
  wire        wr_take  = i_avs_write & ack_r & i_avs_byteenable[0];
  wire [7:0]  wbyte    = i_avs_writedata[7:0];

  assign o_avs_waitrequest = req & ~ack_r;
  assign o_avs_readdata    = rdata_r;

  // ack toggles so back-to-back requests each see one wait state
  always @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= req & ~ack_r;
    end
  end

  // --------------------------------------------------------------------------
  // software registers
  // --------------------------------------------------------------------------
  reg  [CNT_W-1:0] count_r;
  reg  [CNT_W-1:0] reload_r;
  reg  [7:0]       ctrl_a_r;
  reg  [5:0]       ctrl_b_r;
  reg  [CNT_W-1:0] duty_r;
  reg  [7:0]       psc_r;
  reg              bz_en_r;
  reg  [3:0]       bz_fsel_r;
  reg              flag_r;

  wire run_en    = ctrl_a_r[`TPB_A_RUN_ENABLE];
  wire rl_sel    = ctrl_a_r[`TPB_A_RELOAD_SELECT];
  wire one_shot  = ctrl_a_r[`TPB_A_ONE_SHOT];
  wire pwm_al    = ctrl_a_r[`TPB_A_PWM_ACTIVE_LOW];
  wire pwm_oe    = ctrl_a_r[`TPB_A_PWM_OUTPUT_ENABLE];
  wire [2:0] rate = ctrl_b_r[`TPB_B_RATE_MSB:`TPB_B_RATE_LSB];
  wire psc_dis_n = ctrl_b_r[`TPB_B_PRESCALER_DIS_N];
  wire edge_sel  = ctrl_b_r[`TPB_B_EDGE_SELECT];
  wire clk_src   = ctrl_b_r[`TPB_B_CLOCK_SOURCE];

  // write decode
  wire wr_count  = wr_take && (i_avs_address == `TPB_IDX_TIMER_COUNT);
  wire wr_ctrl_a = wr_take && (i_avs_address == `TPB_IDX_TIMER_CONTROL_A);
  wire wr_ctrl_b = wr_take && (i_avs_address == `TPB_IDX_TIMER_CONTROL_B);
  wire wr_duty   = wr_take && (i_avs_address == `TPB_IDX_PWM_DUTY);
  wire wr_bz     = wr_take && (i_avs_address == `TPB_IDX_BUZZER_CONTROL);
  wire wr_status = wr_take && (i_avs_address == `TPB_IDX_STATUS);

  // --------------------------------------------------------------------------
  // clock source and prescaler
  // --------------------------------------------------------------------------
  reg  ext_prev_r;
  wire ext_rise  = i_external_clock_pin & ~ext_prev_r;
  wire ext_fall  = ~i_external_clock_pin & ext_prev_r;
  // external edge or every instruction cycle
  wire src_tick  = clk_src ? (edge_sel ? ext_fall : ext_rise) : 1'b1; // [RULE_14] [RULE_15]

  // prescaler mask: low rate+1 bits of the down counter
  function [7:0] rate_mask;
    input [2:0] code;
    begin
      rate_mask = (8'h02 << code) - 8'h01;
    end
  endfunction

  // fires once every 2^(rate+1) source ticks
  wire psc_tick  = src_tick & ((psc_r & rate_mask(rate)) == 8'h00); // [RULE_11]
  // active-low enable: zero routes through the prescaler
  wire tmr_tick  = psc_dis_n ? src_tick : psc_tick; // [RULE_12]

  always @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ext_prev_r <= 1'b0;
      psc_r      <= `TPB_RST_PRESCALER;
    end else begin
      ext_prev_r <= i_external_clock_pin;
      // prescaler holds while bypassed; rate changes there are glitch-free
      if (!psc_dis_n && src_tick) begin
        psc_r <= psc_r - 8'h01; // [RULE_16]
      end
    end
  end

  // --------------------------------------------------------------------------
  // down counter, reload and underflow
  // --------------------------------------------------------------------------
  wire count_zero = (count_r == {CNT_W{1'b0}});
  wire step       = run_en & tmr_tick; // [RULE_03]
  wire underflow  = step & count_zero;

  always @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      count_r  <= `TPB_RST_TIMER_COUNT;
      reload_r <= `TPB_RST_TIMER_COUNT;
    end else begin
      if (wr_count) begin
        // software load beats a coincident tick
        count_r  <= wbyte; // [RULE_02]
        reload_r <= wbyte; // [RULE_02]
      end else if (underflow) begin
        if (one_shot) begin
          count_r <= count_r; // [RULE_06]
        end else if (rl_sel) begin
          count_r <= reload_r; // [RULE_05] [RULE_10]
        end else begin
          count_r <= `TPB_TIMER_WRAP; // [RULE_04]
        end
      end else if (step) begin
        count_r <= count_r - {{(CNT_W-1){1'b0}}, 1'b1};
      end
    end
  end

  // --------------------------------------------------------------------------
  // control registers; one-shot drops run enable so software sees the stop
  // --------------------------------------------------------------------------
  always @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ctrl_a_r  <= `TPB_RST_CONTROL_A;
      ctrl_b_r  <= `TPB_RST_CONTROL_B;
      duty_r    <= `TPB_RST_PWM_DUTY;
      bz_en_r   <= 1'b0;
      bz_fsel_r <= `TPB_RST_BUZZER_FSEL;
    end else begin
      if (wr_ctrl_a) begin
        ctrl_a_r <= {wbyte[7:6], 3'b000, wbyte[2:0]};
      end else if (underflow && one_shot) begin
        ctrl_a_r[`TPB_A_RUN_ENABLE] <= 1'b0; // [RULE_06]
      end
      if (wr_ctrl_b) begin
        ctrl_b_r <= wbyte[5:0];
      end
      if (wr_duty) begin
        duty_r <= wbyte;
      end
      if (wr_bz) begin
        bz_en_r   <= wbyte[`TPB_BZ_ENABLE];
        bz_fsel_r <= wbyte[`TPB_BZ_FSEL_MSB:`TPB_BZ_FSEL_LSB];
      end
    end
  end

  // sticky underflow flag, write one to clear; a new underflow wins the clear
  always @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      flag_r <= 1'b0;
    end else if (underflow) begin
      flag_r <= 1'b1; // [RULE_21]
    end else if (wr_status && wbyte[`TPB_ST_UNDERFLOW]) begin
      flag_r <= 1'b0; // [RULE_21]
    end
  end

  assign o_underflow_flag = flag_r;

  // --------------------------------------------------------------------------
  // pwm: inactive from start, active from duty match to underflow
  // --------------------------------------------------------------------------
  reg  pwm_act_r;
  wire run_start = wr_ctrl_a & wbyte[`TPB_A_RUN_ENABLE] & ~run_en;

  always @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pwm_act_r <= 1'b0;
    end else if (run_start || underflow) begin
      pwm_act_r <= 1'b0; // [RULE_09] [RULE_10]
    end else if (run_en && (count_r == duty_r)) begin
      pwm_act_r <= 1'b1; // [RULE_09] [RULE_10]
    end
  end

  wire pwm_wave = pwm_act_r ^ pwm_al; // [RULE_07]

  // --------------------------------------------------------------------------
  // buzzer: divider on the prescaler output, or a timer bit
  // --------------------------------------------------------------------------
  reg  [7:0] bz_div_r;
  // bypassed prescaler passes the raw source ticks as its output
  wire psc_out = psc_dis_n ? src_tick : psc_tick;

  always @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      bz_div_r <= 8'h00;
    end else if (psc_out) begin
      bz_div_r <= bz_div_r + 8'h01;
    end
  end

  // bit k of an up counter toggles at tick rate / 2^k
  wire bz_wave = bz_fsel_r[3] ? count_r[bz_fsel_r[2:0]]  // [RULE_18]
                              : bz_div_r[bz_fsel_r[2:0]]; // [RULE_17]

  // --------------------------------------------------------------------------
  // shared pin mux, registered
  // --------------------------------------------------------------------------
  reg pin_r;
  reg pin_oe_r;

  always @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pin_r    <= 1'b0;
      pin_oe_r <= 1'b0;
    end else if (pwm_oe) begin
      pin_r    <= pwm_wave; // [RULE_08] [RULE_22]
      pin_oe_r <= 1'b1;
    end else if (bz_en_r) begin
      pin_r    <= bz_wave; // [RULE_19]
      pin_oe_r <= 1'b1;
    end else begin
      pin_r    <= i_gpio_out; // [RULE_08]
      pin_oe_r <= i_gpio_oe;
    end
  end

  assign o_port_pin_two    = pin_r;
  assign o_port_pin_two_oe = pin_oe_r;

  // --------------------------------------------------------------------------
  // read mux, captured in the wait cycle; write-only fields read zero
  // --------------------------------------------------------------------------
  always @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rdata_r <= 32'h00000000;
    end else if (i_avs_read && !ack_r) begin
      if (i_avs_address == `TPB_IDX_TIMER_COUNT) begin
        rdata_r <= {24'h000000, count_r}; // [RULE_01]
      end else if (i_avs_address == `TPB_IDX_TIMER_CONTROL_A) begin
        rdata_r <= {29'h00000000, ctrl_a_r[2:0]};
      end else if (i_avs_address == `TPB_IDX_TIMER_CONTROL_B) begin
        rdata_r <= {26'h0000000, ctrl_b_r};
      end else if (i_avs_address == `TPB_IDX_PRESCALER_VALUE) begin
        rdata_r <= {24'h000000, psc_r}; // [RULE_16]
      end else if (i_avs_address == `TPB_IDX_STATUS) begin
        rdata_r <= {31'h00000000, flag_r};
      end else begin
        rdata_r <= 32'h00000000; // [RULE_20]
      end
    end
  end

endmodule

/* File: common/tpb_regs.vh */
// register offsets, field positions and reset values for the timer/pwm/buzzer block
`ifndef TPB_REGS_VH
`define TPB_REGS_VH

// ----------------------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------------------
`define TPB_IDX_TIMER_COUNT     3'h0
`define TPB_IDX_TIMER_CONTROL_A 3'h1
`define TPB_IDX_TIMER_CONTROL_B 3'h2
`define TPB_IDX_PWM_DUTY        3'h3
`define TPB_IDX_PRESCALER_VALUE 3'h4
`define TPB_IDX_BUZZER_CONTROL  3'h5
`define TPB_IDX_STATUS          3'h6

// ----------------------------------------------------------------------------
// timer_control_a fields
// ----------------------------------------------------------------------------
`define TPB_A_RUN_ENABLE        0
`define TPB_A_RELOAD_SELECT     1
`define TPB_A_ONE_SHOT          2
`define TPB_A_PWM_ACTIVE_LOW    6
`define TPB_A_PWM_OUTPUT_ENABLE 7

// ----------------------------------------------------------------------------
// timer_control_b fields
// ----------------------------------------------------------------------------
`define TPB_B_RATE_LSB          0
`define TPB_B_RATE_MSB          2
`define TPB_B_PRESCALER_DIS_N   3
`define TPB_B_EDGE_SELECT       4
`define TPB_B_CLOCK_SOURCE      5

// ----------------------------------------------------------------------------
// buzzer_control and status fields
// ----------------------------------------------------------------------------
`define TPB_BZ_FSEL_LSB         0
`define TPB_BZ_FSEL_MSB         3
`define TPB_BZ_ENABLE           7
`define TPB_ST_UNDERFLOW        0

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define TPB_RST_TIMER_COUNT     8'h00
`define TPB_RST_CONTROL_A       8'h00
`define TPB_RST_CONTROL_B       6'h3F
`define TPB_RST_PWM_DUTY        8'h00
`define TPB_RST_PRESCALER       8'hFF
`define TPB_RST_BUZZER_FSEL     4'hF
`define TPB_TIMER_WRAP          8'hFF

`endif

/* File: verification/tpb_timer_monitor.sv */
// port checker for the timer/pwm/buzzer block
`timescale 1ns/100ps
module tpb_timer_monitor #(parameter CNT_W = 8) (
  input wire logic        i_core_clk,
  input wire logic        i_rst_n,
  input wire logic [2:0]  i_avs_address,
  input wire logic        i_avs_read,
  input wire logic        i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0]  i_avs_byteenable,
  input wire logic [31:0] o_avs_readdata,
  input wire logic        o_avs_waitrequest,
  input wire logic        i_external_clock_pin,
  input wire logic        i_gpio_out,
  input wire logic        i_gpio_oe,
  input wire logic        o_port_pin_two,
  input wire logic        o_port_pin_two_oe,
  input wire logic        o_underflow_flag
);
  logic pwm_en_r;
  logic bz_en_r;
  wire  wr_ok = i_avs_write && !o_avs_waitrequest && i_avs_byteenable[0];
  wire  rd_ok = i_avs_read && !o_avs_waitrequest;
  // shadow pin owners; they land on the same edge as the register write
  always @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pwm_en_r <= 1'b0;
      bz_en_r  <= 1'b0;
    end else if (wr_ok) begin
      if (i_avs_address == 3'h1) pwm_en_r <= i_avs_writedata[7];
      if (i_avs_address == 3'h5) bz_en_r <= i_avs_writedata[7];
    end
  end
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);
  sequence s_wait; (i_avs_read || i_avs_write) && o_avs_waitrequest; endsequence
  sequence s_done; (i_avs_read || i_avs_write) && !o_avs_waitrequest; endsequence
  a_one_wait: assert property (s_wait |=> s_done)
    else $error("bus wait state longer than one cycle");
  a_idle_ready: assert property (!(i_avs_read || i_avs_write) |-> !o_avs_waitrequest)
    else $error("waitrequest high while idle");
  a_flag_sticky: assert property (o_underflow_flag && !(wr_ok && i_avs_address == 3'h6
    && i_avs_writedata[0]) |=> o_underflow_flag) else $error("underflow flag dropped");
  a_duty_hidden: assert property (rd_ok && i_avs_address == 3'h3 |-> o_avs_readdata == 32'h0)
    else $error("duty register readable");
  a_ctrl_wo_bits: assert property (rd_ok && i_avs_address == 3'h1 |-> o_avs_readdata[7:3] == 5'h00)
    else $error("pwm control bits readable");
  a_gpio_follow: assert property (!pwm_en_r && !bz_en_r |=> o_port_pin_two == $past(i_gpio_out)
    && o_port_pin_two_oe == $past(i_gpio_oe)) else $error("pin not following gpio");
  a_pwm_drives: assert property (pwm_en_r |=> o_port_pin_two_oe)
    else $error("pwm enabled but pin not driven");
  a_buzz_drives: assert property (bz_en_r |=> o_port_pin_two_oe)
    else $error("buzzer enabled but pin not driven");
  a_reset_quiet: assert property ($rose(i_rst_n) |-> !o_port_pin_two_oe && !o_underflow_flag)
    else $error("pin or flag active out of reset");
endmodule
bind tpb_timer tpb_timer_monitor #(.CNT_W(CNT_W)) u_mon (.i_core_clk, .i_rst_n, .i_avs_address,
  .i_avs_read, .i_avs_write, .i_avs_writedata, .i_avs_byteenable, .o_avs_readdata, .o_avs_waitrequest,
  .i_external_clock_pin, .i_gpio_out, .i_gpio_oe, .o_port_pin_two, .o_port_pin_two_oe, .o_underflow_flag);

/* File: verification/tpb_pin_model.sv */
// far-side model: bursts of edges on the external clock pin
`timescale 1ns/100ps
module tpb_pin_model (
  input  wire logic       i_core_clk,
  input  wire logic       i_start,
  input  wire logic [7:0] i_edges,
  input  wire logic [1:0] i_half,
  output logic            o_ext_clk
);
  logic [7:0] left_r = 8'h00;
  logic [1:0] ph_r   = 2'h0;
  initial o_ext_clk = 1'b0;
  // pin rests between bursts; i_half picks a prompt or slow edge rate
  always @(posedge i_core_clk) begin
    if (i_start) begin
      left_r <= i_edges;
      ph_r   <= 2'h0;
    end else if (left_r != 8'h00 && ph_r == i_half) begin
      ph_r      <= 2'h0;
      o_ext_clk <= ~o_ext_clk;
      left_r    <= left_r - 8'h01;
    end else if (left_r != 8'h00) begin
      ph_r <= ph_r + 2'h1;
    end
  end
endmodule

/* File: verification/tb_top.sv */
// self-checking bench for the timer/pwm/buzzer block
`timescale 1ns/100ps
module tb_top;
  logic        clk = 0, rst_n = 0, rd_q = 0, wr_q = 0, go = 0, g_out = 0, g_oe = 0;
  logic [1:0]  hlf = 0;
  logic [2:0]  adr = 0;
  logic [7:0]  wd = 0, edg = 0, d, e;
  wire  [31:0] rdat;
  wire         wq, pin, oe, flag, ext;
  int          n_errors = 0, tests_run = 0, cyc = 0, hi, tg;
  // ----
  // clock, design, pin model
  // ----
  initial forever #5 clk = ~clk;
  tpb_timer DUT (.i_core_clk(clk), .i_rst_n(rst_n), .i_avs_address(adr), .i_avs_read(rd_q),
    .i_avs_write(wr_q), .i_avs_writedata({24'h000000, wd}), .i_avs_byteenable(4'hF),
    .o_avs_readdata(rdat), .o_avs_waitrequest(wq), .i_external_clock_pin(ext), .i_gpio_out(g_out),
    .i_gpio_oe(g_oe), .o_port_pin_two(pin), .o_port_pin_two_oe(oe), .o_underflow_flag(flag));
  tpb_pin_model PM (.i_core_clk(clk), .i_start(go), .i_edges(edg), .i_half(hlf), .o_ext_clk(ext));
  // hang guard; the full run needs far fewer cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      close_out;
    end
  end
  task check(input logic [7:0] s, input logic [7:0] x);
    tests_run++;
    if (s !== x) begin
      n_errors++;
      $display("Error t=%0t seen %h exp %h", $time, s, x);
    end
  endtask
  // one access: request held until the rising edge that sees waitrequest low,
  // data taken at that edge, then one idle edge so requests never merge
  task acc(input logic w, input logic [2:0] a, input logic [7:0] v);
    adr  <= a;
    wd   <= v;
    wr_q <= w;
    rd_q <= !w;
    do @(posedge clk); while (wq);
    d = rdat[7:0];
    wr_q <= 1'b0;
    rd_q <= 1'b0;
    @(posedge clk);
  endtask
  // counts high samples and transitions of the pin
  task sample(input int n);
    logic l;
    hi = 0;
    tg = 0;
    @(negedge clk);
    l = pin;
    repeat (n) begin
      @(negedge clk);
      hi += int'(pin);
      tg += int'(pin != l);
      l = pin;
    end
  endtask
  task t_regs;
    acc(0, 3'h2, 8'h00);
    check(d, 8'h3F);
    acc(0, 3'h4, 8'h00);
    check(d, 8'hFF);
    acc(0, 3'h7, 8'h00);
    check(d, 8'h00);
    acc(1, 3'h2, 8'h08);
    acc(1, 3'h0, 8'h40);
    acc(0, 3'h0, 8'h00);
    check(d, 8'h40);
    acc(1, 3'h1, 8'h01);
    acc(0, 3'h0, 8'h00);
    e = d;
    acc(0, 3'h0, 8'h00);
    check(e - d, 8'h03);
  endtask
  task t_mode(input logic [7:0] c, input logic [7:0] lo, input logic [7:0] hv);
    acc(1, 3'h1, 8'h00);
    acc(1, 3'h6, 8'h01);
    check({7'h00, flag}, 8'h00);
    acc(1, 3'h0, 8'h05);
    acc(1, 3'h1, c);
    // wait on rising edges so the next request still starts after one
    for (int k = 0; k < 300 && flag !== 1'b1; k++) @(posedge clk);
    check({7'h00, flag}, 8'h01);
    acc(0, 3'h0, 8'h00);
    check(8'(d >= lo && d <= hv), 8'h01);
  endtask
  task t_pwm(input logic al);
    acc(1, 3'h1, 8'h00);
    acc(1, 3'h0, 8'h0F);
    acc(1, 3'h3, 8'h05);
    acc(1, 3'h1, {1'b1, al, 6'h03});
    repeat (40) @(posedge clk);
    sample(64);
    check({7'h00, oe}, 8'h01);
    check(8'(al ? 64 - hi : hi), 8'h14);
    check(8'(tg), 8'h08);
  endtask
  task t_buzz;
    acc(1, 3'h1, 8'h03);
    for (int c = 0; c < 12; c++) begin
      if (c < 4 || c > 7) begin
        acc(1, 3'h5, 8'h80 | 8'(c));
        sample(32);
        check(8'(tg), 8'(32 >> (c % 8)));
      end
    end
    acc(1, 3'h5, 8'h88);
    acc(1, 3'h1, 8'h83);
    repeat (40) @(posedge clk);
    sample(32);
    check(8'(hi), 8'h0A);
    acc(1, 3'h1, 8'h03);
    acc(1, 3'h5, 8'h08);
    g_out <= 1'b1;
    g_oe  <= 1'b1;
    repeat (2) @(posedge clk);
    sample(16);
    check(8'(hi - tg), 8'h10);
  endtask
  // 9 edges from rest give 5 of the selected kind
  task t_ext(input logic [7:0] cb, input logic [1:0] h);
    acc(1, 3'h1, 8'h00);
    acc(1, 3'h2, cb);
    acc(1, 3'h0, 8'h40);
    acc(1, 3'h1, 8'h01);
    edg <= 8'h09;
    hlf <= h;
    go  <= 1'b1;
    @(posedge clk);
    go  <= 1'b0;
    repeat (40) @(posedge clk);
    acc(0, 3'h0, 8'h00);
    check(8'h40 - d, 8'h05);
  endtask
  // reads 64 cycles apart; rate only moved while bypassed
  task t_psc;
    for (int k = 0; k < 6; k++) begin
      acc(1, 3'h2, 8'h08 | 8'(k));
      acc(1, 3'h2, k < 5 ? 8'(k) : 8'h08);
      acc(1, 3'h0, 8'hF0);
      acc(0, 3'h0, 8'h00);
      e = d;
      repeat (61) @(posedge clk);
      acc(0, 3'h0, 8'h00);
      check(e - d, k < 5 ? 8'h20 >> k : 8'h40);
    end
  endtask
  task close_out;
    $display("errors %0d compares %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_regs;
    t_mode(8'h01, 8'hF0, 8'hFF);
    t_mode(8'h03, 8'h00, 8'h05);
    t_mode(8'h07, 8'h00, 8'h00);
    t_pwm(1'b0);
    t_pwm(1'b1);
    t_buzz;
    t_ext(8'h28, 2'h2);
    t_ext(8'h38, 2'h0);
    t_psc;
    close_out;
  end
endmodule
